// [rtl/psd_pkg.sv]
// Purpose: shared constants and types of the phase shifted string dimmer
// Assumes: core_clk at 200 MHz, one clock domain
// Notes:   counts are in core_clk cycles
//
// Overview of operation
// - Every enabled string output copies the frequency and duty of the dimming input, each string starting at an evenly spaced offset within the period.
// - When fault handling disables strings, the offsets are recomputed so only the remaining enabled strings share the even spacing.
// - In two-input mode the frequency and stagger timing come from the sync input and the duty from the dimming input.
// - Frequency and duty may instead come from internally held settings rather than from the pins.
// - With staggerEn set staggering is on, with offsets derived from the enabled string count and the present frequency.
package psd_pkg;

    localparam int unsigned CLK_FREQ_HZ     = 200_000_000;
    localparam int unsigned MIN_DIM_FREQ_HZ = 20;
    localparam int unsigned MAX_DIM_FREQ_HZ = 50_000;
    // longest legal period; beyond it the frequency source counts as lost
    localparam int unsigned LOST_CYC        = CLK_FREQ_HZ / MIN_DIM_FREQ_HZ;
    localparam int unsigned SHORT_CYC       = CLK_FREQ_HZ / MAX_DIM_FREQ_HZ;
    localparam int unsigned CNT_W           = 24;
    localparam int unsigned NUM_STR_DEF     = 8;

    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;

    // mode switches, plus the period and high time that replace the pins when regMode is set
    typedef struct packed {
        logic             regMode;
        logic             syncMode;
        logic             staggerEn;
        logic [CNT_W-1:0] regPeriod;
        logic [CNT_W-1:0] regHigh;
    } psd_cfg_t;

endpackage : psd_pkg

// [rtl/psd_step_div.sv]
// Purpose: restoring divider giving the stagger step, period over string count
// Assumes: start is honoured only while idle
// Notes:   one quotient bit per cycle
`timescale 1ns/1ps
module psd_step_div
    import psd_pkg::*;
#(
    parameter int unsigned NW = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] num,
    input  wire logic [NW-1:0]    den,
    output logic                  busy,
    output logic [CNT_W-1:0]      quo
);

    // the bit index is five bits wide, and the count must fit below the dividend width
    if (NW < 1 || NW >= CNT_W || CNT_W > 32) begin : g_chk
        $error("psd_step_div: unsupported parameter values");
    end

    typedef struct packed {
        logic             busy;
        logic [4:0]       bitIdx;
        logic [CNT_W-1:0] dividend;
        logic [CNT_W:0]   rem;
        logic [CNT_W-1:0] acc;
        logic [CNT_W-1:0] quo;
    } psd_div_st_t;

    psd_div_st_t st_q, st_d;
    logic [CNT_W:0] trial;

    always_comb begin
        st_d  = st_q;
        trial = {st_q.rem[CNT_W-1:0], st_q.dividend[CNT_W-1]};
        if (!st_q.busy) begin
            if (start && den != '0) begin
                st_d.busy     = 1'b1;
                st_d.bitIdx   = 5'(CNT_W - 1);
                st_d.dividend = num;
                st_d.rem      = '0;
                st_d.acc      = '0;
            end
        end else begin
            st_d.dividend = {st_q.dividend[CNT_W-2:0], 1'b0};
            if (trial >= (CNT_W+1)'(den)) begin
                st_d.rem = trial - (CNT_W+1)'(den);
                st_d.acc = {st_q.acc[CNT_W-2:0], 1'b1};
            end else begin
                st_d.rem = trial;
                st_d.acc = {st_q.acc[CNT_W-2:0], 1'b0};
            end
            if (st_q.bitIdx == '0) begin
                st_d.busy = 1'b0;
                st_d.quo  = st_d.acc;
            end else begin
                st_d.bitIdx = st_q.bitIdx - 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = st_q.busy;
    assign quo  = st_q.quo;

endmodule : psd_step_div

// [rtl/psd_string_dimmer.sv]
// Purpose: per-string dimming pulse trains with even phase stagger
// Assumes: pins dimIn and syncIn are asynchronous; stringEn comes from fault logic on core_clk
// Notes:   period and high time are measured over one period and applied to the next
`timescale 1ns/1ps
module psd_string_dimmer
    import psd_pkg::*;
#(
    parameter int unsigned NUM_STR  = NUM_STR_DEF,
    parameter int unsigned LOST_MAX = LOST_CYC
) (
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               dimIn,
    input  wire logic               syncIn,
    input  wire logic [NUM_STR-1:0] stringEn,
    input  wire psd_cfg_t           cfg,
    output logic [NUM_STR-1:0]      dimOut,
    output logic                    freqLost
);

    localparam int unsigned NW = $clog2(NUM_STR + 1);

    if (NUM_STR < 1 || NUM_STR > 16 || LOST_MAX < 2 || LOST_MAX >= (1 << CNT_W)) begin : g_chk
        $error("psd_string_dimmer: unsupported parameter values");
    end

    typedef struct packed {
        logic [1:0]         dimSy;
        logic [1:0]         syncSy;
        logic               freqSrcLast;
        logic [CNT_W-1:0]   phase;
        logic [CNT_W-1:0]   hiAcc;
        logic [CNT_W-1:0]   period;
        logic [CNT_W-1:0]   high;
        logic [CNT_W-1:0]   step;
        logic               lost;
        logic [NUM_STR-1:0] out;
    } psd_st_t;

    psd_st_t            st_q, st_d;
    logic               divBusy;
    logic [CNT_W-1:0]   divQuo;
    logic [NW-1:0]      enCnt;
    wire  [NW-1:0]      rankChain [NUM_STR+1];
    wire  [NUM_STR-1:0] strOn;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // running count of enabled strings: each string's slot, and the total at the end
    assign rankChain[0] = '0;

    for (genvar k = 0; k < NUM_STR; k++) begin : g_rank
        assign rankChain[k+1] = rankChain[k] + NW'(stringEn[k]);
    end

    assign enCnt = rankChain[NUM_STR];

    // keeps recomputing, so a change of enables or period shows within a few dozen cycles
    psd_step_div #(
        .NW (NW)
    ) u_step_div (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .start    (!divBusy),
        .num      (st_q.period),
        .den      (enCnt),
        .busy     (divBusy),
        .quo      (divQuo)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // frequency source, edge and level helpers
    logic             dimLvl;
    logic             freqSrc;
    logic             freqEdge;
    logic             regWrap;
    logic             atLimit;
    logic [CNT_W-1:0] phaseNext;
    logic [CNT_W-1:0] hiNext;
    logic [CNT_W-1:0] effHigh;
    logic             holdLevel;

    // only the second stage of each synchroniser is read
    assign dimLvl    = st_q.dimSy[1];
    assign freqSrc   = cfg.syncMode ? st_q.syncSy[1] : dimLvl;
    assign phaseNext = st_q.phase + CNT_ONE;
    // register mode makes its own period edge from the phase counter
    assign regWrap   = (phaseNext >= cfg.regPeriod);
    assign freqEdge  = cfg.regMode ? regWrap : (freqSrc && !st_q.freqSrcLast);
    // no edge within the longest legal period: the source counts as lost
    assign atLimit   = (phaseNext >= CNT_W'(LOST_MAX));
    // the edge cycle of a pulse is counted in the period that it closes
    assign hiNext    = dimLvl ? st_q.hiAcc + CNT_ONE : st_q.hiAcc;
    // a high time beyond the period means fully on
    assign effHigh   = (st_q.high > st_q.period) ? st_q.period : st_q.high;
    // with no usable edges, enabled strings follow the level: off at 0 %, on at 100 %
    assign holdLevel = st_q.lost && !cfg.regMode;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // period and high time measurement, stagger step and output register
    always_comb begin
        st_d             = st_q;
        st_d.dimSy       = {st_q.dimSy[0], dimIn};
        st_d.syncSy      = {st_q.syncSy[0], syncIn};
        st_d.freqSrcLast = freqSrc;
        if (freqEdge) begin
            st_d.phase = CNT_ZERO;
            st_d.hiAcc = CNT_ZERO;
            st_d.lost  = 1'b0;
            if (cfg.regMode) begin
                st_d.period = cfg.regPeriod;
                st_d.high   = cfg.regHigh;
            end else begin
                st_d.period = phaseNext;
                st_d.high   = hiNext;
            end
        end else begin
            st_d.hiAcc = hiNext;
            if (atLimit) begin
                st_d.lost = 1'b1;
            end else begin
                st_d.phase = phaseNext;
            end
        end
        // the step is taken only while the divider holds a finished quotient
        if (!divBusy) begin
            st_d.step = divQuo;
        end
        st_d.out = strOn;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // per-string start offset and pulse
    for (genvar k = 0; k < NUM_STR; k++) begin : g_str
        logic [CNT_W-1:0] offs;
        logic [CNT_W-1:0] diff;

        // slot among the enabled strings times the step; all start together without stagger
        assign offs = cfg.staggerEn ? CNT_W'(st_q.step * rankChain[k]) : CNT_ZERO;
        // distance from this string's own start, wrapped into the period
        assign diff = (st_q.phase >= offs) ? st_q.phase - offs
                                           : st_q.phase + st_q.period - offs;
        // a disabled string stays dark whatever the source does
        assign strOn[k] = stringEn[k] && (holdLevel ? dimLvl : (diff < effHigh));
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dimOut   = st_q.out;
    assign freqLost = st_q.lost;

endmodule : psd_string_dimmer

// [verification/psd_string_dimmer_checker.sv]
// Purpose: port checks of the string dimmer
// Assumes: one clock, reset active low
// Notes:   bound to psd_string_dimmer
`timescale 1ns/1ps
module psd_string_dimmer_checker
    import psd_pkg::*;
#(
    parameter int unsigned NUM_STR  = NUM_STR_DEF,
    parameter int unsigned LOST_MAX = LOST_CYC
) (
    input wire logic               core_clk,
    input wire logic               rst_b,
    input wire logic               dimIn,
    input wire logic               syncIn,
    input wire logic [NUM_STR-1:0] stringEn,
    input wire psd_cfg_t           cfg,
    input wire logic [NUM_STR-1:0] dimOut,
    input wire logic               freqLost
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic        srcPrev_q;
    logic        modePrev_q;
    int unsigned idle_q;
    wire         src = cfg.syncMode ? syncIn : dimIn;
    // cycles since the last rising edge of the frequency source
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            srcPrev_q  <= 1'b0;
            modePrev_q <= 1'b0;
            idle_q     <= 0;
        end else begin
            srcPrev_q  <= src;
            modePrev_q <= cfg.syncMode;
            if ((src && !srcPrev_q) || cfg.regMode || cfg.syncMode != modePrev_q) begin
                idle_q <= 0;
            end else begin
                idle_q <= idle_q + 1;
            end
        end
    end
    a_disabled_off: assert property ((~stringEn & ~$past(stringEn) & dimOut) == '0)
        else $error("disabled string driven");
    a_unstaggered_same: assert property (!cfg.staggerEn && !$past(cfg.staggerEn, 64)
        && $stable(stringEn) |-> dimOut == '0 || dimOut == stringEn)
        else $error("unstaggered strings differ");
    a_lost_all_on: assert property ((freqLost && dimIn && !cfg.regMode
        && $stable(stringEn))[*6] |-> dimOut == stringEn)
        else $error("full duty not on");
    a_lost_all_off: assert property ((freqLost && !dimIn && !cfg.regMode)[*6]
        |-> dimOut == '0)
        else $error("zero duty not off");
    a_reg_not_lost: assert property (cfg.regMode && $past(cfg.regMode) |-> !$rose(freqLost))
        else $error("lost raised in register mode");
    a_lost_in_time: assert property (!cfg.regMode && idle_q > LOST_MAX + 8 |-> freqLost)
        else $error("lost source not flagged");
endmodule : psd_string_dimmer_checker

bind psd_string_dimmer psd_string_dimmer_checker #(.NUM_STR(NUM_STR), .LOST_MAX(LOST_MAX)) chkr_i (
    .core_clk(core_clk), .rst_b(rst_b), .dimIn(dimIn), .syncIn(syncIn),
    .stringEn(stringEn), .cfg(cfg), .dimOut(dimOut), .freqLost(freqLost));

// [verification/psd_pwm_host.sv]
// Purpose: host dimming source, dimming and sync pins
// Assumes: changes on the falling edge
// Notes:   sync period is twice the dimming period
`timescale 1ns/1ps
module psd_pwm_host #(
    parameter int PERIOD = 4000,
    parameter int HIGH   = 1000
) (
    input  wire logic core_clk,
    input  wire logic run,
    input  wire logic level,
    output logic      dimIn = 1'b0,
    output logic      syncIn = 1'b0
);
    int cnt = 0;
    always @(negedge core_clk) begin
        cnt    <= (!run || cnt == 2 * PERIOD - 1) ? 0 : cnt + 1;
        dimIn  <= run ? (cnt % PERIOD) < HIGH : level;
        syncIn <= run ? cnt < PERIOD : level;
    end
endmodule : psd_pwm_host

// [verification/testbench.sv]
// Purpose: directed bench of the string dimmer
// Assumes: 4 strings, lost limit cut to 9000 cycles
// Notes:   edges are timed in cycles at the falling edge
`timescale 1ns/1ps
module testbench
    import psd_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       rst_b    = 1'b0;
    logic       run      = 1'b1;
    logic       level    = 1'b0;
    logic [3:0] stringEn = 4'hf;
    psd_cfg_t   cfg      = '{1'b0, 1'b0, 1'b1, 24'h000000, 24'h000000};
    logic [3:0] dimOut;
    logic [3:0] prevOut  = 4'h0;
    logic       dimIn, syncIn, freqLost;
    int         cyc = 0, mismatches = 0, compares = 0;
    int         rise[4], hi[4];
    always #2.5 core_clk = ~core_clk;
    psd_pwm_host psd_pwm_host_i (.core_clk(core_clk), .run(run), .level(level),
        .dimIn(dimIn), .syncIn(syncIn));
    psd_string_dimmer #(.NUM_STR(4), .LOST_MAX(9000)) psd_string_dimmer_i (
        .core_clk(core_clk), .rst_b(rst_b), .dimIn(dimIn), .syncIn(syncIn),
        .stringEn(stringEn), .cfg(cfg), .dimOut(dimOut), .freqLost(freqLost));
    always @(negedge core_clk) begin
        cyc     <= cyc + 1;
        prevOut <= dimOut;
        for (int k = 0; k < 4; k++) begin
            if (dimOut[k] && !prevOut[k]) rise[k] <= cyc;
            if (!dimOut[k] && prevOut[k]) hi[k] <= cyc - rise[k];
        end
    end
    task automatic chkN(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkN
    task automatic chkV(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkV
    // offset from string 0 and high time of every enabled string
    task automatic measure(input int p, input int step, input int h);
        int rank;
        rank = 0;
        repeat (3 * p) @(negedge core_clk);
        chkV({3'h0, freqLost}, 4'h0);
        for (int k = 0; k < 4; k++) begin
            if (stringEn[k]) begin
                chkN(((rise[k] - rise[0]) % p + p) % p, rank * step);
                chkN(hi[k], h);
                rank++;
            end else chkV({3'h0, dimOut[k]}, 4'h0);
        end
    endtask : measure
    task automatic wrap_up;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////
    task automatic t_stagger;
        measure(4000, 1000, 1000);
        cfg.staggerEn = 1'b0;
        measure(4000, 0, 1000);
        cfg.staggerEn = 1'b1;
        $display("stagger done");
    endtask : t_stagger
    task automatic t_fault;
        stringEn = 4'hd;
        measure(4000, 1333, 1000);
        stringEn = 4'hf;
        $display("fault done");
    endtask : t_fault
    task automatic t_sync;
        cfg.syncMode = 1'b1;
        measure(8000, 2000, 2000);
        cfg.syncMode = 1'b0;
        $display("sync done");
    endtask : t_sync
    task automatic t_reg;
        run = 1'b0;
        cfg.regMode = 1'b1;
        cfg.regPeriod = 24'h001770;
        cfg.regHigh = 24'h0005dc;
        measure(6000, 1500, 1500);
        cfg.regMode = 1'b0;
        $display("register mode done");
    endtask : t_reg
    task automatic t_full;
        level = 1'b1;
        repeat (9100) @(negedge core_clk);
        chkV(dimOut, stringEn);
        chkV({3'h0, freqLost}, 4'h1);
        level = 1'b0;
        repeat (10) @(negedge core_clk);
        chkV(dimOut, 4'h0);
        $display("full and zero duty done");
    endtask : t_full
    task automatic t_reset;
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        chkV(dimOut, 4'h0);
        chkV({3'h0, freqLost}, 4'h0);
        rst_b = 1'b1;
        repeat (2) @(negedge core_clk);
        chkV(dimOut, 4'h0);
        $display("mid-run reset done");
    endtask : t_reset
    initial begin
        repeat (8) @(negedge core_clk);
        rst_b = 1'b1;
        t_stagger();
        t_fault();
        t_sync();
        t_reg();
        t_full();
        t_reset();
        wrap_up();
    end
    initial begin
        repeat (95000) @(posedge core_clk);
        mismatches++;
        wrap_up();
    end
endmodule : testbench
